// >>> hdl/pio_defines.vh
// Register offsets, widths and reset values for the shared parallel port
`ifndef PIO_DEFINES_VH
`define PIO_DEFINES_VH
`define PIO_W            16
`define PIO_AW           4
`define PIO_ZERO         16'h0000
`define PIO_ONES         16'hffff
`define PIO_ADDR_DIR     4'h0
`define PIO_ADDR_PIN     4'h1
`define PIO_ADDR_LAT     4'h2
`define PIO_ADDR_ANA     4'h3
`define PIO_ADDR_IMPL    4'h4
`define PIO_ADDR_ANCAP   4'h5
`define PIO_DIR_RESET    16'hffff
`define PIO_LAT_RESET    16'h0000
`define PIO_ANA_RESET    16'h0000
`endif

// >>> hdl/pad_owner_mux.v
// Per-pin ownership multiplexers between peripheral and port
`timescale 1ns/100ps
module pad_owner_mux (
	// Port side
	input  wire [15:0] port_out_i,
	input  wire [15:0] port_oe_i,
	// Peripheral side
	input  wire [15:0] periph_en_i,
	input  wire [15:0] periph_drive_i,
	input  wire [15:0] periph_out_i,
	// Pad side
	output wire [15:0] pad_out_o,
	output wire [15:0] pad_oe_o
);
	wire [15:0] owner;
	// Peripheral owns pad while enabled and driving
	assign owner     = periph_en_i & periph_drive_i;
	assign pad_out_o = (owner & periph_out_i) | (~owner & port_out_i);
	assign pad_oe_o  = owner | (~owner & port_oe_i);
endmodule

// >>> hdl/shared_parallel_io_port.v
// Shared parallel I/O port with direction, latch, pin read and analog config
`timescale 1ns/100ps
`include "pio_defines.vh"
module shared_parallel_io_port #(
	parameter [15:0] IMPL_MASK  = 16'hffff,
	parameter [15:0] ANCAP_MASK = 16'h00ff
) (
	// Clock and reset
	input  wire        clk_sys_i,
	input  wire        srst_i,
	// Register port
	input  wire [3:0]  addr_i,
	input  wire [15:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [15:0] rdata_o,
	// Pad cells
	input  wire [15:0] pad_in_i,
	output reg  [15:0] pad_out_o,
	output reg  [15:0] pad_oe_o,
	// Peripherals
	input  wire [15:0] periph_en_i,
	input  wire [15:0] periph_drive_i,
	input  wire [15:0] periph_out_i,
	// Converter inputs
	output reg  [15:0] analog_sel_o,
	output reg  [15:0] digital_in_o
);
	reg  [15:0] pin_direction_reg;
	reg  [15:0] output_latch_reg;
	reg  [15:0] analog_pin_config_reg;
	reg  [15:0] pin_sample;
	reg  [15:0] next_rdata;
	wire [15:0] mux_out;
	wire [15:0] mux_oe;
	wire [15:0] ana_mode;
	wire [15:0] pin_read_reg;

	function [15:0] impl_only;
		input [15:0] v;
		begin
			impl_only = v & IMPL_MASK;
		end
	endfunction

	// Analog mode on capable pins whose config bit is set
	assign ana_mode = analog_pin_config_reg & ANCAP_MASK;
	// Pin levels, analog pins read as low
	assign pin_read_reg = impl_only(pin_sample & ~ana_mode);

	// Every pin goes through the owner mux
	pad_owner_mux u_mux (
		.port_out_i     (output_latch_reg),
		.port_oe_i      (impl_only(~pin_direction_reg)),
		.periph_en_i    (periph_en_i & IMPL_MASK),
		.periph_drive_i (periph_drive_i),
		.periph_out_i   (periph_out_i),
		.pad_out_o      (mux_out),
		.pad_oe_o       (mux_oe)
	);

	// Register writes
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			pin_direction_reg     <= impl_only(`PIO_DIR_RESET);
			output_latch_reg      <= `PIO_LAT_RESET;
			analog_pin_config_reg <= `PIO_ANA_RESET;
		end else if (wr_i) begin
			case (addr_i)
				`PIO_ADDR_DIR: pin_direction_reg <= impl_only(wdata_i);
				`PIO_ADDR_PIN: output_latch_reg <= impl_only(wdata_i);
				`PIO_ADDR_LAT: output_latch_reg <= impl_only(wdata_i);
				`PIO_ADDR_ANA: analog_pin_config_reg <= wdata_i & ANCAP_MASK;
				default: ;
			endcase
		end
	end

	// Read mux
	always @* begin
		next_rdata = `PIO_ZERO;
		case (addr_i)
			`PIO_ADDR_DIR:   next_rdata = impl_only(pin_direction_reg);
			`PIO_ADDR_PIN:   next_rdata = pin_read_reg;
			`PIO_ADDR_LAT:   next_rdata = impl_only(output_latch_reg);
			`PIO_ADDR_ANA:   next_rdata = analog_pin_config_reg;
			`PIO_ADDR_IMPL:  next_rdata = IMPL_MASK;
			`PIO_ADDR_ANCAP: next_rdata = ANCAP_MASK;
			default:         next_rdata = `PIO_ZERO;
		endcase
	end

	// Registered outputs and pin sampling
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			rdata_o      <= `PIO_ZERO;
			pin_sample   <= `PIO_ZERO;
			pad_out_o    <= `PIO_ZERO;
			pad_oe_o     <= `PIO_ZERO;
			analog_sel_o <= `PIO_ZERO;
			digital_in_o <= `PIO_ZERO;
		end else begin
			rdata_o      <= rd_i ? next_rdata : `PIO_ZERO;
			pin_sample   <= pad_in_i;
			pad_out_o    <= mux_out & IMPL_MASK;
			pad_oe_o     <= mux_oe & IMPL_MASK;
			// Converter sees pin only in analog mode
			analog_sel_o <= ana_mode & IMPL_MASK;
			digital_in_o <= pin_read_reg;
		end
	end
endmodule

// >>> bench/pio_props.sv
// Port checker
`timescale 1ns/100ps
module pio_props #(parameter [15:0] IMPL_MASK = 16'hffff, ANCAP_MASK = 16'h00ff) (
	input wire        clk_sys_i, srst_i, rd_i,
	input wire [3:0]  addr_i,
	input wire [15:0] rdata_o, pad_out_o, pad_oe_o, analog_sel_o,
	input wire [15:0] periph_en_i, periph_drive_i, periph_out_i
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	wire [15:0] own = periph_en_i & periph_drive_i;
	own_data_a: assert property (((pad_out_o ^ $past(periph_out_i)) & $past(own)) == 0)
		else $error("pad data");
	own_drive_a: assert property (($past(own) & ~pad_oe_o) == 0) else $error("pad oe");
	rst_input_a: assert property ($past(srst_i) |-> (pad_oe_o & ~$past(own)) == 0)
		else $error("reset oe");
	rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 0) else $error("rdata");
	rd_impl_a: assert property ($past(rd_i && addr_i == 4'h4) |-> rdata_o == IMPL_MASK)
		else $error("impl");
	unimpl_rd_a: assert property ((rdata_o & ~IMPL_MASK) == 0) else $error("unimpl");
	unimpl_oe_a: assert property ((pad_oe_o & ~IMPL_MASK & ~$past(own)) == 0)
		else $error("unimpl oe");
	ancap_sel_a: assert property ((analog_sel_o & ~ANCAP_MASK) == 0) else $error("ana");
endmodule
bind shared_parallel_io_port pio_props #(.IMPL_MASK(IMPL_MASK), .ANCAP_MASK(ANCAP_MASK)) chk (.*);

// >>> bench/pad_partner.sv
// Pad model
`timescale 1ns/100ps
module pad_partner (
	input wire [15:0]  pad_out_i, pad_oe_i, ext_i,
	output wire [15:0] pad_o
);
	assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule

// >>> bench/shared_parallel_io_port_tb.sv
// Port testbench
`timescale 1ns/100ps
module shared_parallel_io_port_tb;
	reg         clk_sys_i = 0, srst_i = 1, wr_i = 0, rd_i = 0;
	reg  [3:0]  addr_i = 0;
	reg  [15:0] wdata_i = 0, ext = 0, en = 0, drv = 0, po = 0;
	wire [15:0] rdata_o, pad, pad_out_o, pad_oe_o, asel, dig;
	integer     n_fail = 0, num_checks = 0;
	always #2.5 clk_sys_i = ~clk_sys_i;
	shared_parallel_io_port #(.IMPL_MASK(16'h7fff)) dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.pad_in_i(pad), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .periph_en_i(en),
		.periph_drive_i(drv), .periph_out_i(po), .analog_sel_o(asel), .digital_in_o(dig));
	pad_partner pp (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .ext_i(ext), .pad_o(pad));
	task chk(input [15:0] g, e);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("wrong value at %0t: %h", $time, g);
			end
		end
	endtask
	task wr(input [3:0] a, input [15:0] d);
		begin
			@(posedge clk_sys_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
			@(posedge clk_sys_i) wr_i <= 0;
		end
	endtask
	task rd(input [3:0] a, input [15:0] e);
		begin
			@(posedge clk_sys_i) {rd_i, addr_i} <= {1'b1, a};
			@(posedge clk_sys_i) rd_i <= 0;
			@(negedge clk_sys_i) chk(rdata_o, e);
		end
	endtask
	task settle;
		repeat (3) @(negedge clk_sys_i);
	endtask
	task close_out;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_fail);
			if (n_fail == 0 && num_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	initial begin
		repeat (12) @(posedge clk_sys_i);
		srst_i <= 0;
		rd(0, 16'h7fff);
		rd(2, 0);
		rd(5, 16'h00ff);
		rd(6, 0);
		$display("reset test done");
		wr(1, 16'ha5a5);
		rd(2, 16'h25a5);
		wr(0, 0);
		settle;
		chk(pad_oe_o, 16'h7fff);
		chk(pad_out_o, 16'h25a5);
		rd(1, 16'h25a5);
		$display("latch test done");
		wr(0, 16'hffff);
		@(posedge clk_sys_i) ext <= 16'h1234;
		wr(3, 16'h000f);
		settle;
		rd(1, 16'h1230);
		chk(asel, 16'h000f);
		wr(3, 16'hffff);
		settle;
		rd(1, 16'h1200);
		chk(dig, 16'h1200);
		chk(asel, 16'h00ff);
		$display("analog test done");
		wr(0, 0);
		wr(3, 0);
		@(posedge clk_sys_i) {en, drv, po} <= {16'h0003, 16'h0001, 16'h0002};
		settle;
		chk(pad_out_o & 16'h3, 0);
		rd(1, 16'h25a4);
		$display("peripheral test done");
		close_out;
	end
	initial begin
		#20000;
		n_fail = n_fail + 1;
		close_out;
	end
endmodule
